// ### can_bus_model.sv
// Purpose: behavioural model of the differential bus and a remote node
// Assumes: bus decisions are ideal, no analog delay
// Notes:   mid_band puts the differential into the undefined band
`timescale 1ns/1ps
module can_bus_model (
    input wire logic canh_drive_hi,
    input wire logic canl_drive_lo,
    input wire logic remote_dom,
    input wire logic mid_band,
    output logic bus_dom_main,
    output logic bus_rec_main,
    output logic bus_dom_lowpower
);
    logic bus_dom;

    // wired bus: either node driving makes it dominant
    assign bus_dom = remote_dom | (canh_drive_hi & canl_drive_lo);
    // main comparators, both low in the undefined band
    assign bus_dom_main = bus_dom & !mid_band;
    assign bus_rec_main = !bus_dom & !mid_band;
    // low-power receiver sees the same bus level
    assign bus_dom_lowpower = bus_dom;
endmodule // can_bus_model

// ### can_transceiver_mode_wake_logic.sv
// Purpose: mode control, driver/receiver steering and remote wake
//          qualification for a CAN physical-layer transceiver
// Assumes: analog comparators deliver bus decisions as digital levels;
//          all pins are asynchronous to clk
// Notes:   filtered phases pass through an event buffer to the sequencer
`timescale 1ns/1ps

// Function
// - low power select high means standby
// - standby: driver off, monitor on, rxd high
// - normal: driver and receiver active, rxd follows
// - shutdown: everything off, rxd high, bias ground
// - normal: txd low drives dominant, else recessive
// - standby/shutdown ignore txd, pins released
// - rxd low at dominant, high at recessive
// - wake needs dominant, recessive, dominant filtered
// - unfiltered activity never restarts the monitor
// - every later filtered dominant pulls rxd low
// - wake shown as falling rxd, low period
// - filtered means persisting beyond filter time
// - short states never count, long always
// - filter met by one slow bit
// - pattern not complete in window restarts detection
// - power off select overrides low power select
// - floating inputs settle to safe defaults
module can_transceiver_mode_wake_logic #(
    parameter int WAKE_WINDOW_CYCLES = can_wake_pkg::WAKE_WINDOW_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic txd_in,
    input wire logic low_power_select,
    input wire logic power_off_select,
    input wire logic bus_dom_main,
    input wire logic bus_rec_main,
    input wire logic bus_dom_lowpower,
    output logic rxd_out,
    output logic canh_drive_hi,
    output logic canl_drive_lo,
    output logic bus_bias_rec,
    output logic bus_bias_gnd,
    output logic main_rx_en,
    output logic lp_rx_en,
    output logic mode_normal,
    output logic mode_standby,
    output logic mode_shutdown
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [can_wake_pkg::PIN_N-1:0] pin_raw;
    logic [can_wake_pkg::PIN_N-1:0] pin_meta_q;
    logic [can_wake_pkg::PIN_N-1:0] pin_sync_q;

    assign pin_raw = {txd_in, low_power_select, power_off_select, bus_dom_main, bus_rec_main, bus_dom_lowpower};

    // two flops per pin; reset values are the safe floating defaults
    genvar gi;
    generate
        for (gi = 0; gi < can_wake_pkg::PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pin_meta_q[gi] <= can_wake_pkg::PIN_RST[gi];
                    pin_sync_q[gi] <= can_wake_pkg::PIN_RST[gi];
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                end
            end
        end
    endgenerate

    wire logic txd_s = pin_sync_q[5];
    wire logic lps_s = pin_sync_q[4];
    wire logic pos_s = pin_sync_q[3];
    wire logic main_dom_s = pin_sync_q[2];
    wire logic main_rec_s = pin_sync_q[1];
    wire logic lp_dom_s = pin_sync_q[0];

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    can_wake_pkg::mode_t mode_q;
    can_wake_pkg::mode_t mode_d;

    // power off wins over low power select
    assign mode_d = pos_s ? can_wake_pkg::MODE_SHUTDOWN :
                    lps_s ? can_wake_pkg::MODE_STANDBY :
                    can_wake_pkg::MODE_NORMAL;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= can_wake_pkg::MODE_STANDBY;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire logic in_normal = (mode_q == can_wake_pkg::MODE_NORMAL);
    wire logic in_standby = (mode_q == can_wake_pkg::MODE_STANDBY);

    // ----------------------------------------------------------------
    // phase filter on the low-power receiver
    // ----------------------------------------------------------------
    logic filt_lvl_q;
    logic [can_wake_pkg::FILT_W-1:0] filt_cnt_q;
    logic filt_sent_q;

    wake_evt_if push_ch ();
    wake_evt_if pop_ch ();

    // phase counts as filtered once it outlasts the filter time
    wire logic filt_change = (lp_dom_s != filt_lvl_q);
    wire logic filt_hit = !filt_change && (filt_cnt_q == can_wake_pkg::FILT_LIMIT);
    wire logic filt_push = push_ch.valid && push_ch.ready;

    assign push_ch.valid = in_standby && filt_hit && !filt_sent_q;
    assign push_ch.data = filt_lvl_q;

    // counter saturates, so a stalled event waits for buffer space
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt_lvl_q <= 1'b0;
            filt_cnt_q <= '0;
            filt_sent_q <= 1'b0;
        end else if (!in_standby || filt_change) begin
            filt_lvl_q <= lp_dom_s;
            filt_cnt_q <= '0;
            filt_sent_q <= 1'b0;
        end else begin
            if (!filt_hit) begin
                filt_cnt_q <= filt_cnt_q + 1'b1;
            end
            if (filt_push) begin
                filt_sent_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // event buffer, emptied outside standby
    // ----------------------------------------------------------------
    wake_evt_fifo #(
        .WIDTH(can_wake_pkg::EVT_W),
        .DEPTH(can_wake_pkg::EVT_DEPTH)
    ) u_evt_fifo (
        .clk(clk),
        .resetn(resetn),
        .flush(!in_standby),
        .wr(push_ch),
        .rd(pop_ch)
    );

    // ----------------------------------------------------------------
    // wake pattern sequencer
    // ----------------------------------------------------------------
    can_wake_pkg::seq_t seq_q;
    can_wake_pkg::seq_t seq_d;
    logic [can_wake_pkg::WIN_W-1:0] win_q;
    logic indicate_q;
    logic indicate_d;

    localparam logic [can_wake_pkg::WIN_W-1:0] WIN_LIMIT = can_wake_pkg::WIN_W'(WAKE_WINDOW_CYCLES);

    // sequencer stalls while the host is shown a wake low period
    assign pop_ch.ready = in_standby && !indicate_q;

    wire logic evt_pop = pop_ch.valid && pop_ch.ready;
    wire logic pop_dom = evt_pop && (pop_ch.data == can_wake_pkg::EVT_DOMINANT);
    wire logic pop_rec = evt_pop && (pop_ch.data != can_wake_pkg::EVT_DOMINANT);
    wire logic seq_armed = (seq_q == can_wake_pkg::SEQ_WAIT_REC) || (seq_q == can_wake_pkg::SEQ_WAIT_DOM);
    wire logic win_expired = seq_armed && (win_q >= WIN_LIMIT) && !pop_dom;

    // next pattern state; other events leave progress untouched
    always_comb begin
        seq_d = seq_q;
        if (!in_standby) begin
            seq_d = can_wake_pkg::SEQ_IDLE;
        end else if (win_expired) begin
            seq_d = can_wake_pkg::SEQ_IDLE;
        end else begin
            unique case (seq_q)
                can_wake_pkg::SEQ_IDLE: begin
                    if (pop_dom) begin
                        seq_d = can_wake_pkg::SEQ_WAIT_REC;
                    end
                end
                can_wake_pkg::SEQ_WAIT_REC: begin
                    if (pop_rec) begin
                        seq_d = can_wake_pkg::SEQ_WAIT_DOM;
                    end
                end
                can_wake_pkg::SEQ_WAIT_DOM: begin
                    if (pop_dom) begin
                        seq_d = can_wake_pkg::SEQ_WOKE;
                    end
                end
                can_wake_pkg::SEQ_WOKE: begin
                    seq_d = can_wake_pkg::SEQ_WOKE;
                end
            endcase
        end
    end

    // low period starts on a qualifying dominant, ends when the bus leaves dominant
    always_comb begin
        indicate_d = indicate_q;
        if (!in_standby) begin
            indicate_d = 1'b0;
        end else if (pop_dom && ((seq_q == can_wake_pkg::SEQ_WAIT_DOM) || (seq_q == can_wake_pkg::SEQ_WOKE))) begin
            indicate_d = !win_expired;
        end else if (indicate_q && !lp_dom_s) begin
            indicate_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seq_q <= can_wake_pkg::SEQ_IDLE;
            indicate_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            indicate_q <= indicate_d;
        end
    end

    // window runs from the first filtered dominant
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_q <= '0;
        end else if (seq_d == can_wake_pkg::SEQ_WAIT_REC && seq_q == can_wake_pkg::SEQ_IDLE) begin
            win_q <= '0;
        end else if (seq_armed && (win_q < WIN_LIMIT)) begin
            win_q <= win_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // receive output
    // ----------------------------------------------------------------
    logic rxd_q;
    logic rxd_d;

    // normal follows the bus with hysteresis; other modes stay high unless waking
    always_comb begin
        rxd_d = 1'b1;
        if (in_normal) begin
            if (main_dom_s) begin
                rxd_d = 1'b0;
            end else if (main_rec_s) begin
                rxd_d = 1'b1;
            end else begin
                rxd_d = rxd_q; // undefined band holds
            end
        end else if (in_standby) begin
            rxd_d = !indicate_d;
        end else begin
            rxd_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= rxd_d;
        end
    end

    // ----------------------------------------------------------------
    // driver, bias and receiver enables
    // ----------------------------------------------------------------
    logic drive_dom_q;
    logic bias_rec_q;
    logic bias_gnd_q;
    logic main_en_q;
    logic lp_en_q;

    wire logic drive_dom_d = (mode_d == can_wake_pkg::MODE_NORMAL) && !txd_s;
    wire logic normal_d = (mode_d == can_wake_pkg::MODE_NORMAL);
    wire logic standby_d = (mode_d == can_wake_pkg::MODE_STANDBY);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_dom_q <= 1'b0;
            bias_rec_q <= 1'b0;
            bias_gnd_q <= 1'b1;
            main_en_q <= 1'b0;
            lp_en_q <= 1'b1;
        end else begin
            drive_dom_q <= drive_dom_d;
            bias_rec_q <= normal_d;
            bias_gnd_q <= !normal_d;
            main_en_q <= normal_d;
            lp_en_q <= standby_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rxd_out = rxd_q;
    assign canh_drive_hi = drive_dom_q;
    assign canl_drive_lo = drive_dom_q;
    assign bus_bias_rec = bias_rec_q;
    assign bus_bias_gnd = bias_gnd_q;
    assign main_rx_en = main_en_q;
    assign lp_rx_en = lp_en_q;
    assign mode_normal = (mode_q == can_wake_pkg::MODE_NORMAL);
    assign mode_standby = (mode_q == can_wake_pkg::MODE_STANDBY);
    assign mode_shutdown = (mode_q == can_wake_pkg::MODE_SHUTDOWN);

endmodule // can_transceiver_mode_wake_logic

// ### can_wake_monitor.sv
// Purpose: port-level checks of mode, driver, receiver and wake behaviour
// Assumes: pins pass two sync flops plus one output flop
// Notes:   dom_run_q measures how long the bus has been dominant
`timescale 1ns/1ps
module can_wake_monitor #(
    parameter int WAKE_WINDOW_CYCLES = 50000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic txd_in,
    input wire logic low_power_select,
    input wire logic power_off_select,
    input wire logic bus_dom_main,
    input wire logic bus_rec_main,
    input wire logic bus_dom_lowpower,
    input wire logic rxd_out,
    input wire logic canh_drive_hi,
    input wire logic canl_drive_lo,
    input wire logic bus_bias_rec,
    input wire logic bus_bias_gnd,
    input wire logic main_rx_en,
    input wire logic lp_rx_en,
    input wire logic mode_normal,
    input wire logic mode_standby,
    input wire logic mode_shutdown
);
    logic [7:0] dom_run_q;
    logic [7:0] dom_run_d;

    // saturating run length of a dominant low-power level
    assign dom_run_d = !bus_dom_lowpower ? 8'h00 : (dom_run_q == 8'hff) ? dom_run_q : dom_run_q + 8'h01;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dom_run_q <= 8'h00;
        end else begin
            dom_run_q <= dom_run_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // mode selection, three edges of latency
    chk_mode_onehot: assert property ($onehot({mode_normal, mode_standby, mode_shutdown}))
        else $error("mode outputs not one-hot");
    chk_shutdown_prio: assert property (power_off_select [*4] |-> mode_shutdown)
        else $error("power off select did not force shutdown");
    chk_standby_sel: assert property ((low_power_select && !power_off_select) [*4] |-> mode_standby)
        else $error("standby not entered");
    chk_normal_sel: assert property ((!low_power_select && !power_off_select) [*4] |-> mode_normal)
        else $error("normal not entered");
    // driver steering
    chk_drive_quiet: assert property (!mode_normal |-> !canh_drive_hi)
        else $error("driver on outside normal");
    chk_drive_pair: assert property (canh_drive_hi == canl_drive_lo)
        else $error("bus drivers disagree");
    chk_tx_dominant: assert property ((mode_normal && !txd_in) [*4] |-> canh_drive_hi)
        else $error("low transmit input not driven");
    chk_tx_recessive: assert property ((mode_normal && txd_in) [*4] |-> !canh_drive_hi && bus_bias_rec)
        else $error("high transmit input drove bus");
    // bias and receivers outside normal
    chk_sleep_bias: assert property (!mode_normal |-> bus_bias_gnd && !bus_bias_rec && !main_rx_en)
        else $error("bias or main receiver wrong outside normal");
    chk_shutdown_quiet: assert property (mode_shutdown [*2] |-> !lp_rx_en && rxd_out)
        else $error("shutdown left receiver on or rxd low");
    // receive path in normal
    chk_rx_dominant: assert property ((mode_normal && bus_dom_main && !bus_rec_main) [*4] |-> !rxd_out)
        else $error("rxd not low on dominant");
    chk_rx_recessive: assert property ((mode_normal && bus_rec_main && !bus_dom_main) [*4] |-> rxd_out)
        else $error("rxd not high on recessive");
    // a wake indication needs a dominant of at least 76 samples
    chk_wake_filtered: assert property (mode_standby && $fell(rxd_out) |-> dom_run_q >= 8'h4c)
        else $error("wake indicated on unfiltered dominant");

    cov_wake: cover property (mode_standby && $fell(rxd_out));
    cov_shutdown_bus: cover property (mode_shutdown && bus_dom_lowpower);
    cov_tx: cover property (mode_normal && canh_drive_hi);
endmodule // can_wake_monitor

bind can_transceiver_mode_wake_logic can_wake_monitor #(.WAKE_WINDOW_CYCLES(WAKE_WINDOW_CYCLES)) can_wake_monitor_i (
    .clk, .resetn, .txd_in, .low_power_select, .power_off_select, .bus_dom_main, .bus_rec_main,
    .bus_dom_lowpower, .rxd_out, .canh_drive_hi, .canl_drive_lo, .bus_bias_rec, .bus_bias_gnd,
    .main_rx_en, .lp_rx_en, .mode_normal, .mode_standby, .mode_shutdown
);

// ### can_wake_pkg.sv
// Purpose: shared constants and types for the transceiver mode and wake logic
// Assumes: 50 MHz system clock, one event bit per filtered bus phase
// Notes:   all cycle counts derive from times in their own units
package can_wake_pkg;

    // ----------------------------------------------------------------
    // clock and bit timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int RATE_SLOW_KBPS = 500;
    localparam int RATE_FAST_KBPS = 1000;
    localparam int BIT_SLOW_NS = 1000000 / RATE_SLOW_KBPS; // one bit at the slow rate
    localparam int BIT_FAST_PAIR_NS = 2 * 1000000 / RATE_FAST_KBPS; // two bits at the fast rate

    // ----------------------------------------------------------------
    // wake filter and wake window
    // ----------------------------------------------------------------
    // filter sits below both bit spans so either satisfies it
    localparam int WAKE_FILTER_TIME_NS = 1500;
    localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W = 8;
    localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(WAKE_FILTER_CYCLES);
    localparam int WAKE_WINDOW_TIME_US = 1000;
    localparam int WAKE_WINDOW_CYCLES = WAKE_WINDOW_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int WIN_W = 20;

    // ----------------------------------------------------------------
    // input synchroniser reset values, one bit per pin
    // order: txd, low_power_select, power_off_select, main dom, main rec, lp dom
    // ----------------------------------------------------------------
    localparam int PIN_N = 6;
    localparam logic [PIN_N-1:0] PIN_RST = 6'h32;

    // ----------------------------------------------------------------
    // event buffer
    // ----------------------------------------------------------------
    localparam int EVT_W = 1;
    localparam int EVT_DEPTH = 16;
    localparam logic [EVT_W-1:0] EVT_DOMINANT = 1'h1;

    // ----------------------------------------------------------------
    // state encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,
        MODE_STANDBY = 3'h2,
        MODE_SHUTDOWN = 3'h4
    } mode_t;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_WAIT_REC = 4'h2,
        SEQ_WAIT_DOM = 4'h4,
        SEQ_WOKE = 4'h8
    } seq_t;

endpackage

// ### tb_can_transceiver_mode_wake_logic.sv
// Purpose: self-checking bench for mode control and remote wake
// Assumes: wake window shortened to 2000 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_can_transceiver_mode_wake_logic;
    logic clk, resetn, txd_in, low_power_select, power_off_select, remote_dom, mid_band;
    logic bus_dom_main, bus_rec_main, bus_dom_lowpower, rxd_out, canh_drive_hi, canl_drive_lo;
    logic bus_bias_rec, bus_bias_gnd, main_rx_en, lp_rx_en, mode_normal, mode_standby, mode_shutdown;
    logic seen_low;
    int num_errors = 0;
    int comparisons = 0;

    can_transceiver_mode_wake_logic #(.WAKE_WINDOW_CYCLES(2000)) can_transceiver_mode_wake_logic_i (
        .clk, .resetn, .txd_in, .low_power_select, .power_off_select, .bus_dom_main, .bus_rec_main,
        .bus_dom_lowpower, .rxd_out, .canh_drive_hi, .canl_drive_lo, .bus_bias_rec, .bus_bias_gnd,
        .main_rx_en, .lp_rx_en, .mode_normal, .mode_standby, .mode_shutdown
    );
    can_bus_model can_bus_model_i (
        .canh_drive_hi, .canl_drive_lo, .remote_dom, .mid_band, .bus_dom_main, .bus_rec_main, .bus_dom_lowpower
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // hold a bus level, noting any low rxd
    task automatic phase(input logic lvl, input int k);
        remote_dom = lvl;
        repeat (k) begin
            cyc(1);
            if (rxd_out !== 1'b1) seen_low = 1'b1;
        end
    endtask

    // dominant that must raise a wake indication
    task automatic wake_dom(input string name);
        int k;
        k = 0;
        remote_dom = 1'b1;
        while (rxd_out !== 1'b0 && k < 120) begin
            cyc(1);
            k++;
        end
        check(name, k >= 76 && k <= 90, 1'b1);
        cyc(100 - k);
        check("wake_low", rxd_out, 1'b0);
        remote_dom = 1'b0;
        cyc(6);
        check("wake_end", rxd_out, 1'b1);
    endtask

    task automatic t_reset();
        check("rst_mode", mode_standby, 1'b1);
        check("rst_rxd", rxd_out, 1'b1);
        check("rst_lp", lp_rx_en, 1'b1);
    endtask

    task automatic t_normal();
        low_power_select = 1'b0;
        cyc(4);
        check("nrm_mode", mode_normal, 1'b1);
        check("nrm_rx", main_rx_en & !lp_rx_en, 1'b1);
        txd_in = 1'b0;
        cyc(4);
        check("nrm_drive", canh_drive_hi & canl_drive_lo, 1'b1);
        cyc(4);
        check("nrm_loop", rxd_out, 1'b0);
        txd_in = 1'b1;
        cyc(8);
        check("nrm_release", !canh_drive_hi & rxd_out, 1'b1);
        remote_dom = 1'b1;
        cyc(4);
        check("nrm_remote", rxd_out, 1'b0);
        mid_band = 1'b1;
        remote_dom = 1'b0;
        cyc(6);
        check("nrm_hold", rxd_out, 1'b0);
        mid_band = 1'b0;
        cyc(4);
        check("nrm_rec", rxd_out, 1'b1);
    endtask

    task automatic t_standby_quiet();
        low_power_select = 1'b1;
        txd_in = 1'b0;
        cyc(4);
        check("sby_mode", mode_standby, 1'b1);
        check("sby_drive", canh_drive_hi | canl_drive_lo, 1'b0);
        check("sby_bias", bus_bias_gnd & !main_rx_en, 1'b1);
        seen_low = 1'b0;
        repeat (6) begin
            phase(1'b1, 60);
            phase(1'b0, 60);
        end
        check("sby_short", seen_low, 1'b0);
        txd_in = 1'b1;
    endtask

    task automatic t_wake();
        seen_low = 1'b0;
        phase(1'b1, 100);
        phase(1'b0, 30);
        phase(1'b1, 100);
        phase(1'b0, 100);
        phase(1'b1, 20);
        phase(1'b0, 100);
        check("wk_early", seen_low, 1'b0);
        wake_dom("wk_first");
        phase(1'b0, 100);
        wake_dom("wk_again");
        low_power_select = 1'b0;
        cyc(4);
        check("wk_resume", mode_normal, 1'b1);
    endtask

    task automatic t_timeout();
        low_power_select = 1'b1;
        cyc(4);
        seen_low = 1'b0;
        phase(1'b1, 100);
        phase(1'b0, 2100);
        phase(1'b1, 100);
        phase(1'b0, 100);
        check("to_nowake", seen_low, 1'b0);
        check("to_mode", mode_standby, 1'b1);
        wake_dom("to_rewake");
    endtask

    task automatic t_shutdown();
        power_off_select = 1'b1;
        txd_in = 1'b0;
        cyc(4);
        check("sd_mode", mode_shutdown, 1'b1);
        check("sd_rx", lp_rx_en | main_rx_en | canh_drive_hi, 1'b0);
        check("sd_bias", bus_bias_gnd, 1'b1);
        seen_low = 1'b0;
        for (int i = 0; i < 5; i++) begin
            phase(i % 2 == 0, 100);
        end
        check("sd_nowake", seen_low, 1'b0);
        low_power_select = 1'b0;
        cyc(4);
        check("sd_prio", mode_shutdown, 1'b1);
        power_off_select = 1'b0;
        txd_in = 1'b1;
        cyc(4);
        check("sd_exit", mode_normal, 1'b1);
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        txd_in = 1'b1;
        low_power_select = 1'b1;
        power_off_select = 1'b0;
        remote_dom = 1'b0;
        mid_band = 1'b0;
        seen_low = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        resetn = 1'b1;
        cyc(2);
        t_reset();
        t_normal();
        t_standby_quiet();
        t_wake();
        t_timeout();
        t_shutdown();
        give_verdict();
    end

    // watchdog well beyond the expected run
    initial begin
        #1_000_000;
        num_errors++;
        give_verdict();
    end
endmodule // tb_can_transceiver_mode_wake_logic

// ### wake_evt_fifo.sv
// Purpose: parameterised event buffer between phase filter and wake sequencer
// Assumes: writer holds data while valid and not ready
// Notes:   flush empties the buffer synchronously
`timescale 1ns/1ps
module wake_evt_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    wake_evt_if.snk wr,
    wake_evt_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;

    // ----------------------------------------------------------------
    // status and handshake
    // ----------------------------------------------------------------
    wire logic empty = (wptr_q == rptr_q);
    wire logic full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wire logic push = wr.valid && !full;
    wire logic pop = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_q[AW-1:0]];

    // pointers carry one extra wrap bit to tell full from empty
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else if (flush) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wptr_q[AW-1:0]] <= wr.data;
        end
    end

endmodule // wake_evt_fifo

// ### wake_evt_if.sv
// Purpose: valid/ready carrier for filtered bus phase events
// Assumes: one clock domain
// Notes:   data bit is the bus level of the phase, 1 for dominant
`timescale 1ns/1ps
interface wake_evt_if;
    logic valid;
    logic ready;
    logic [can_wake_pkg::EVT_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
